// ### common/pdr_defs.vh
// Offsets, reset values and field positions for the
// playback datapath register bank.
// Assumes a word-addressed register port; offsets below are word indices.
`ifndef PDR_DEFS_VH
`define PDR_DEFS_VH

// ==========================================================================
// Register offsets (word indices).
`define PDR_A_IRQ_MASK      16'h000a
`define PDR_A_IRQ_STATUS    16'h000b
`define PDR_A_FRAME_COUNT   16'h000c
`define PDR_A_REC_INV_LO    16'h1000
`define PDR_A_REC_INV_HI    16'h1001
`define PDR_A_IM_INV_LO     16'h1002
`define PDR_A_IM_INV_HI     16'h1003
`define PDR_A_FPS           16'h1004
`define PDR_A_TC_LO         16'h1005
`define PDR_A_TC_HI         16'h1006
`define PDR_A_TICK_COUNT    16'h1007
`define PDR_A_XBAR_BASE     16'h2000
`define PDR_A_UNPACK        16'h2020
`define PDR_A_BANK_A        16'h3000
`define PDR_A_BANK_B        16'h3100
`define PDR_A_DERR_LO       16'h4000
`define PDR_A_DERR_HI       16'h4001
`define PDR_A_DRATE_LO      16'h4002
`define PDR_A_DRATE_HI      16'h4003

// ==========================================================================
// Reset values.
`define PDR_R_REC_INV_LO    16'h0055
`define PDR_R_REC_INV_HI    16'h00aa
`define PDR_R_IM_INV_LO     16'h0033
`define PDR_R_IM_INV_HI     16'h00cc
`define PDR_R_FPS           15'h0100
`define PDR_R_DERR_LO       16'h0000
`define PDR_R_DERR_HI       16'hfff0
`define PDR_R_DRATE_LO      16'hffff
`define PDR_R_DRATE_HI      2'h3

// ==========================================================================
// Interrupt bit positions and field positions.
`define PDR_IRQ_TICK        0
`define PDR_IRQ_SRC_PPS     1
`define PDR_IRQ_FRAME       2
`define PDR_IRQ_TVR         3
`define PDR_IRQ_SYS_PPS     4
`define PDR_IRQ_PHASE       5
`define PDR_IRQ_BITS        6
`define PDR_UNPACK_ONE_BIT  15
`define PDR_DRATE_MODE      15
`define PDR_BANK_DEPTH      240

`endif

// ### hdl/pdr_playback_regs.v
// Playback datapath register bank: interrupt status, frame counters,
// header-strip patterns and time code capture, unpack crossbar, header RAM
// banks and lower delay generator registers.
// Assumes one 200 MHz clock, word-addressed register port, synchronous data.
// Assumes the read and write strobes never stand in the same cycle.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "pdr_defs.vh"

// DATA_W names the crossbar width, fixed at 32 by the ports; FPS_W is
// the frames per second field and BANK_DEPTH the words in each bank.
module pdr_playback_regs #(
    parameter DATA_W     = 32,
    parameter FPS_W      = 15,
    parameter BANK_DEPTH = `PDR_BANK_DEPTH
) (
    // Clock and reset.
    input  wire        i_sys_clk,
    input  wire        i_rstn,
    // Register port.
    input  wire [15:0] i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [15:0] o_rdata,
    // Event inputs, one-cycle pulses.
    input  wire        i_source_pulse_per_second,
    input  wire        i_frame_start,
    input  wire        i_tvr_result,
    input  wire        i_system_pps,
    input  wire        i_phase_cal,
    // Disk data stream.
    input  wire        i_disk_valid,
    input  wire [31:0] i_disk_word,
    input  wire        i_disk_tick_marker,
    input  wire        i_disk_hdr_word1,
    input  wire        i_disk_frame_end,
    // Crossbar datapath.
    input  wire [31:0] i_xbar_in,
    output reg  [31:0] o_xbar_out,
    // Header RAM read side, one-cycle latency.
    input  wire [7:0]  i_hdr_index,
    output reg  [15:0] o_hdr_word,
    // Configuration outputs.
    output wire [31:0] o_recorder_invalid,
    output wire [31:0] o_input_module_invalid,
    output wire [2:0]  o_unpack_code,
    output wire        o_one_bit_samples,
    output wire [31:0] o_delay_error,
    output wire [17:0] o_delay_rate,
    output wire        o_delay_gen_mode,
    output wire [15:0] o_frame_start_counter,
    output wire        o_irq
);

    // ======================================================================
    // Register storage.
    reg [`PDR_IRQ_BITS-1:0] irq_status;
    reg [`PDR_IRQ_BITS-1:0] irq_mask;

    // Frame start count, read back at its own offset.
    reg [15:0]      frame_start_counter;

    // Invalid-word patterns for the header stripper.
    reg [15:0]      rec_inv_lo;
    reg [15:0]      rec_inv_hi;
    reg [15:0]      im_inv_lo;
    reg [15:0]      im_inv_hi;

    // Disk frame counting and time code capture.
    reg [FPS_W-1:0] frames_per_second;
    reg [FPS_W-1:0] disk_frame_count;
    reg [31:0]      header_time_code;
    reg [31:0]      captured_time_code;
    reg [15:0]      tick_rollover_count;

    // Unpack format and delay generator settings.
    reg [2:0]       unpack_code;
    reg             one_bit_samples;
    reg [15:0]      derr_lo;
    reg [15:0]      derr_hi;
    reg [15:0]      drate_lo;
    reg [1:0]       drate_hi;
    reg             delay_gen_mode;

    // Bank pointer, crossbar selectors and the header words.
    reg             bank_sel_even;
    reg [4:0]       crossbar_source_index [0:31];
    reg [15:0]      header_words_odd  [0:BANK_DEPTH-1];
    reg [15:0]      header_words_even [0:BANK_DEPTH-1];

    // ======================================================================
    // Address decode.
    // Decode is combinational from the address alone. Only the status
    // register has a side effect on read, so it has its own select.
    // Bank indices 240 to 255 belong to neither bank and read as zero.
    // The wrap term compares against one less than the programmed count
    // because the disk frame counter itself starts from zero.
    // A count of zero would compare against 7fff and wrap only after 32768 frames; the count stays fixed.
    wire sel_status = (i_addr == `PDR_A_IRQ_STATUS);
    wire sel_xbar   = (i_addr[15:5] == `PDR_A_XBAR_BASE >> 5);
    wire [7:0] ram_idx = i_addr[7:0];
    wire sel_bank_a = (i_addr[15:8] == `PDR_A_BANK_A >> 8) && (ram_idx < BANK_DEPTH);
    wire sel_bank_b = (i_addr[15:8] == `PDR_A_BANK_B >> 8) && (ram_idx < BANK_DEPTH);
    wire disk_wrap  = i_disk_valid && i_disk_frame_end &&
                      (disk_frame_count == frames_per_second - 1'b1);

    // ======================================================================
    // Interrupt status: events set, a read clears. Set wins over the clear
    // so an event in the read cycle appears on the next read.
    // The bits are sticky: software learns that an event happened since
    // its last read, not how often, so two ticks look like one.
    // A masked bit still latches; unmasking later shows the old event.
    // Bit order follows the status word; the tick is qualified by valid.
    wire [`PDR_IRQ_BITS-1:0] irq_events = {
        i_phase_cal,
        i_system_pps,
        i_tvr_result,
        i_frame_start,
        i_source_pulse_per_second,
        i_disk_valid & i_disk_tick_marker
    };
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            irq_status <= {`PDR_IRQ_BITS{1'b0}};
        end else if (i_rd && sel_status) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end
    // Level output: it falls only when software reads the status or
    // masks the source, never on its own.
    assign o_irq = |(irq_status & irq_mask);

    // ======================================================================
    // Counters and time code capture from the disk stream.
    // All counters wrap silently; software that polls them must take
    // differences modulo their width.
    // The time code is staged from header word 1, so a wrap captures
    // the word staged earlier, not one arriving in that same cycle.
    // The bank pointer starts on bank A and flips at every frame start.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            frame_start_counter <= 16'h0000;
            disk_frame_count    <= {FPS_W{1'b0}};
            header_time_code    <= 32'h0000_0000;
            captured_time_code  <= 32'h0000_0000;
            tick_rollover_count <= 16'h0000;
            bank_sel_even       <= 1'b0;
        end else begin
            if (i_frame_start)
                frame_start_counter <= frame_start_counter + 16'h0001;
            if (i_disk_valid && i_disk_hdr_word1)
                header_time_code <= i_disk_word;
            if (i_disk_valid && i_disk_frame_end) begin
                // Counter is zero-based against the programmed value.
                if (disk_wrap) begin
                    disk_frame_count    <= {FPS_W{1'b0}};
                    captured_time_code  <= header_time_code;
                    tick_rollover_count <= tick_rollover_count + 16'h0001;
                end else begin
                    disk_frame_count <= disk_frame_count + 1'b1;
                end
            end
            // Bank toggles at each frame start: odd frame counts use B, even use A.
            if (i_frame_start)
                bank_sel_even <= ~bank_sel_even;
        end
    end

    // ======================================================================
    // Software-written configuration registers.
    // Writes take effect at the next edge. The 32-bit values are split
    // into halves with no atomic update, so software writes both halves
    // while the consumer is idle or accepts one frame with a mixed value.
    // Unimplemented bits of the unpack and rate words read back as zero.
    // Frames per second is read-only and keeps its reset value.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            irq_mask          <= {`PDR_IRQ_BITS{1'b0}};
            rec_inv_lo        <= `PDR_R_REC_INV_LO;
            rec_inv_hi        <= `PDR_R_REC_INV_HI;
            im_inv_lo         <= `PDR_R_IM_INV_LO;
            im_inv_hi         <= `PDR_R_IM_INV_HI;
            frames_per_second <= `PDR_R_FPS;
            unpack_code       <= 3'h0;
            one_bit_samples   <= 1'b0;
            derr_lo           <= `PDR_R_DERR_LO;
            derr_hi           <= `PDR_R_DERR_HI;
            drate_lo          <= `PDR_R_DRATE_LO;
            drate_hi          <= `PDR_R_DRATE_HI;
            delay_gen_mode    <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                `PDR_A_IRQ_MASK:   irq_mask   <= i_wdata[`PDR_IRQ_BITS-1:0];
                `PDR_A_REC_INV_LO: rec_inv_lo <= i_wdata;
                `PDR_A_REC_INV_HI: rec_inv_hi <= i_wdata;
                `PDR_A_IM_INV_LO:  im_inv_lo  <= i_wdata;
                `PDR_A_IM_INV_HI:  im_inv_hi  <= i_wdata;
                // A write to frames per second falls to the default item.
                `PDR_A_UNPACK: begin
                    unpack_code     <= i_wdata[2:0];
                    one_bit_samples <= i_wdata[`PDR_UNPACK_ONE_BIT];
                end
                `PDR_A_DERR_LO:    derr_lo  <= i_wdata;
                `PDR_A_DERR_HI:    derr_hi  <= i_wdata;
                `PDR_A_DRATE_LO:   drate_lo <= i_wdata;
                `PDR_A_DRATE_HI: begin
                    drate_hi       <= i_wdata[1:0];
                    delay_gen_mode <= i_wdata[`PDR_DRATE_MODE];
                end
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Crossbar selectors and the crossbar itself, one slice per output bit.
    // The output is registered, one cycle behind its input. A selector
    // written in one cycle first steers the output after next, so software
    // should change the mapping only while the stream is idle.
    genvar n;
    generate
        for (n = 0; n < 32; n = n + 1) begin : g_slice
            // Reset value of this selector: its own index.
            localparam integer SLICE = n;
            always @(posedge i_sys_clk) begin
                if (!i_rstn)
                    crossbar_source_index[n] <= SLICE[4:0];
                else if (i_wr && sel_xbar && i_addr[4:0] == SLICE[4:0])
                    crossbar_source_index[n] <= i_wdata[4:0];
                o_xbar_out[n] <= i_xbar_in[crossbar_source_index[n]];
            end
        end
    endgenerate

    // ======================================================================
    // Header RAM banks. Contents are not reset; software preloads them.
    // Writes reach the bank named by the address whatever frame runs,
    // so software must refill only the bank that is idle.
    // The read port is a plain registered read. Before the first frame
    // start it reads bank A; each frame start swaps the banks.
    // No reset here keeps both arrays plain block memories.
    always @(posedge i_sys_clk) begin
        if (i_wr && sel_bank_a)
            header_words_odd[ram_idx] <= i_wdata;
        if (i_wr && sel_bank_b)
            header_words_even[ram_idx] <= i_wdata;
        // Out-of-range indices return zero rather than a stale word.
        if (i_hdr_index >= BANK_DEPTH)
            o_hdr_word <= 16'h0000;
        else if (bank_sel_even)
            o_hdr_word <= header_words_even[i_hdr_index];
        else
            o_hdr_word <= header_words_odd[i_hdr_index];
    end

    // ======================================================================
    // Read data, registered one cycle after the read strobe.
    // Read data is zero in every cycle without a read, so a bus that ORs
    // several slaves together needs no further gating.
    // An unmapped offset also reads as zero.
    // Only the status register is disturbed by a read.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            if (sel_xbar)
                o_rdata <= {11'h000, crossbar_source_index[i_addr[4:0]]};
            else if (sel_bank_a)
                o_rdata <= header_words_odd[ram_idx];
            else if (sel_bank_b)
                o_rdata <= header_words_even[ram_idx];
            else begin
                case (i_addr)
                    `PDR_A_IRQ_MASK:    o_rdata <= {10'h000, irq_mask};
                    `PDR_A_IRQ_STATUS:  o_rdata <= {10'h000, irq_status};
                    `PDR_A_FRAME_COUNT: o_rdata <= frame_start_counter;
                    `PDR_A_REC_INV_LO:  o_rdata <= rec_inv_lo;
                    `PDR_A_REC_INV_HI:  o_rdata <= rec_inv_hi;
                    `PDR_A_IM_INV_LO:   o_rdata <= im_inv_lo;
                    `PDR_A_IM_INV_HI:   o_rdata <= im_inv_hi;
                    `PDR_A_FPS:         o_rdata <= {1'b0, frames_per_second};
                    `PDR_A_TC_LO:       o_rdata <= captured_time_code[15:0];
                    `PDR_A_TC_HI:       o_rdata <= captured_time_code[31:16];
                    `PDR_A_TICK_COUNT:  o_rdata <= tick_rollover_count;
                    `PDR_A_UNPACK:      o_rdata <= {one_bit_samples, 12'h000, unpack_code};
                    `PDR_A_DERR_LO:     o_rdata <= derr_lo;
                    `PDR_A_DERR_HI:     o_rdata <= derr_hi;
                    `PDR_A_DRATE_LO:    o_rdata <= drate_lo;
                    `PDR_A_DRATE_HI:    o_rdata <= {delay_gen_mode, 13'h0000, drate_hi};
                    default:            o_rdata <= 16'h0000;
                endcase
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // ======================================================================
    // Configuration outputs.
    // These follow the registers directly; a consumer that needs a
    // value stable for a whole frame must sample it at the frame start.
    // The delay rate spans two registers: bits 17-16 and bits 15-0.
    assign o_recorder_invalid     = {rec_inv_hi, rec_inv_lo};
    assign o_input_module_invalid = {im_inv_hi, im_inv_lo};
    assign o_unpack_code          = unpack_code;
    assign o_one_bit_samples      = one_bit_samples;
    assign o_delay_error          = {derr_hi, derr_lo};
    assign o_delay_rate           = {drate_hi, drate_lo};
    assign o_delay_gen_mode       = delay_gen_mode;
    assign o_frame_start_counter  = frame_start_counter;

endmodule // pdr_playback_regs

// ### verif/pdr_playback_props.sv
// Concurrent checks on the playback register bank ports.
// Assumes one clock, a synchronous active-low reset and a word-addressed port.
`timescale 1ns/10ps
module pdr_playback_props (
    // Clock and reset.
    input wire        i_sys_clk,
    input wire        i_rstn,
    // Register port.
    input wire [15:0] i_addr,
    input wire [15:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [15:0] o_rdata,
    // Events and datapath.
    input wire        i_source_pulse_per_second,
    input wire        i_frame_start,
    input wire        i_tvr_result,
    input wire        i_system_pps,
    input wire        i_phase_cal,
    input wire        i_disk_valid,
    input wire        i_disk_tick_marker,
    input wire [31:0] i_xbar_in,
    input wire [31:0] o_xbar_out,
    input wire [2:0]  o_unpack_code,
    input wire        o_one_bit_samples,
    input wire [15:0] o_frame_start_counter,
    input wire        o_irq
);
    // ==========
    // Helper terms.
    wire tick_ev = i_disk_valid & i_disk_tick_marker;
    wire any_ev  = tick_ev | i_source_pulse_per_second | i_frame_start | i_tvr_result
                 | i_system_pps | i_phase_cal;
    wire st_rd   = i_rd & (i_addr == 16'h000b);
    wire xbar_wr = i_wr & (i_addr[15:5] == 11'h100);
    reg  xbar_set;

    // Any selector write ends the window in which the crossbar must be a thru.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            xbar_set <= 1'b0;
        end else if (xbar_wr) begin
            xbar_set <= 1'b1;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    // ==========
    // Properties.
    property p_rd_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_rd_clear; (st_rd && !any_ev) ##1 st_rd |=> o_rdata == 16'h0000; endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status not cleared");
    property p_tick; tick_ev ##1 st_rd |=> o_rdata[0]; endproperty
    a_tick: assert property (p_tick) else $error("tick bit missing");
    property p_src_pps; i_source_pulse_per_second ##1 st_rd |=> o_rdata[1]; endproperty
    a_src_pps: assert property (p_src_pps) else $error("source pps bit missing");
    property p_frame; i_frame_start ##1 st_rd |=> o_rdata[2]; endproperty
    a_frame: assert property (p_frame) else $error("frame bit missing");
    property p_irq_low; st_rd && !any_ev |=> !o_irq; endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq high after clear");
    property p_fcnt;
        1'b1 |=> o_frame_start_counter ==
                 $past(o_frame_start_counter) + {15'h0000, $past(i_frame_start)};
    endproperty
    a_fcnt: assert property (p_fcnt) else $error("frame counter step wrong");
    property p_xbar; !xbar_set && !xbar_wr |=> o_xbar_out == $past(i_xbar_in); endproperty
    a_xbar: assert property (p_xbar) else $error("crossbar not thru");
    property p_unpack;
        i_wr && i_addr == 16'h2020 |=>
            {o_one_bit_samples, 12'h000, o_unpack_code} == ($past(i_wdata) & 16'h8007);
    endproperty
    a_unpack: assert property (p_unpack) else $error("unpack fields wrong");

    // Main scenarios reached.
    c_double_read: cover property (st_rd ##1 st_rd);
    c_irq: cover property (o_irq);
    c_xbar_write: cover property (xbar_set);
endmodule // pdr_playback_props

bind pdr_playback_regs pdr_playback_props i_pdr_playback_props (
    .i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_source_pulse_per_second, .i_frame_start, .i_tvr_result, .i_system_pps, .i_phase_cal,
    .i_disk_valid, .i_disk_tick_marker, .i_xbar_in, .o_xbar_out, .o_unpack_code,
    .o_one_bit_samples, .o_frame_start_counter, .o_irq
);

// ### verif/testbench.sv
// Self-checking bench for the playback register bank against an integer model.
// Assumes the design samples every input on the rising edge of i_sys_clk.
`timescale 1ns/10ps
`include "pdr_defs.vh"
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

module testbench;
    // ==========
    // Stimulus, outputs and model state.
    reg         i_sys_clk   = 1'b0;
    reg         i_rstn      = 1'b0;
    reg  [15:0] i_addr      = 16'h0000;
    reg  [15:0] i_wdata     = 16'h0000;
    reg         i_wr        = 1'b0;
    reg         i_rd        = 1'b0;
    reg         i_source_pulse_per_second = 1'b0, i_frame_start = 1'b0, i_tvr_result = 1'b0;
    reg         i_system_pps = 1'b0, i_phase_cal = 1'b0, i_disk_valid = 1'b0;
    reg         i_disk_tick_marker = 1'b0, i_disk_hdr_word1 = 1'b0, i_disk_frame_end = 1'b0;
    reg  [31:0] i_disk_word = 32'h00000000;
    reg  [31:0] i_xbar_in   = 32'h00000000;
    reg  [7:0]  i_hdr_index = 8'h00;
    wire [15:0] o_rdata, o_hdr_word, o_frame_start_counter;
    wire [31:0] o_xbar_out, o_recorder_invalid, o_input_module_invalid, o_delay_error;
    wire [17:0] o_delay_rate;
    wire [2:0]  o_unpack_code;
    wire        o_one_bit_samples, o_delay_gen_mode, o_irq;
    int         mem[int], wm[int], al[$];
    int         st = 0, fc = 0, tk = 0, tcode = 0, dcnt = 0, lastw = 0, seed = 13553;
    int         error_cnt = 0, comparisons = 0;
    logic [15:0] rexp = 16'h0000, hexp;
    logic [31:0] xexp;
    bit          hon = 0, xon = 0;

    pdr_playback_regs i_pdr_playback_regs (
        .i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_source_pulse_per_second, .i_frame_start, .i_tvr_result, .i_system_pps, .i_phase_cal,
        .i_disk_valid, .i_disk_word, .i_disk_tick_marker, .i_disk_hdr_word1,
        .i_disk_frame_end, .i_xbar_in, .o_xbar_out, .i_hdr_index, .o_hdr_word,
        .o_recorder_invalid, .o_input_module_invalid, .o_unpack_code, .o_one_bit_samples,
        .o_delay_error, .o_delay_rate, .o_delay_gen_mode, .o_frame_start_counter, .o_irq);

    // ==========
    // Model helpers; unwritten or unmapped places read as zero.
    function automatic logic [15:0] m(int a);
        return mem.exists(a) ? mem[a][15:0] : 16'h0000;
    endfunction
    function automatic logic [15:0] rv(int a);
        case (a)
            `PDR_A_IRQ_STATUS: return st[15:0];
            `PDR_A_FRAME_COUNT: return fc[15:0];
            `PDR_A_TC_LO: return tcode[15:0];
            `PDR_A_TC_HI: return tcode[31:16];
            `PDR_A_TICK_COUNT: return tk[15:0];
            default: return m(a);
        endcase
    endfunction
    task automatic reg_def(int a, int r, int k);
        mem[a] = r;
        wm[a] = k;
    endtask

    // One bus cycle: drive, check what the previous cycle produced, then advance the model.
    task automatic cyc(bit w, bit r, int a, int d, logic [7:0] e);
        int k;
        logic [31:0] dw, xi;
        logic [7:0] hi;
        dw = $random(seed);
        xi = $random(seed);
        hi = $unsigned($random(seed)) % 240;
        @(posedge i_sys_clk);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a[15:0];
        i_wdata <= d[15:0];
        {i_disk_frame_end, i_disk_hdr_word1, i_phase_cal, i_system_pps, i_tvr_result,
            i_frame_start, i_source_pulse_per_second, i_disk_tick_marker} <= e;
        i_disk_valid <= |{e[0], e[6], e[7], dw[31]};
        i_disk_word <= dw;
        i_xbar_in <= xi;
        i_hdr_index <= hi;
        #1;
        `CHK("rdata", rexp, o_rdata)
        `CHK("irq", |(st[5:0] & mem[16'h000a][5:0]), o_irq)
        `CHK("frame count", fc[15:0], o_frame_start_counter)
        `CHK("config", {mem[16'h1001][15:0], mem[16'h1000][15:0], mem[16'h1003][15:0],
            mem[16'h1002][15:0], mem[16'h4001][15:0], mem[16'h4000][15:0],
            mem[16'h4003][1:0], mem[16'h4002][15:0], mem[16'h2020][2:0], mem[16'h2020][15]},
            {o_recorder_invalid, o_input_module_invalid, o_delay_error, o_delay_rate,
            o_unpack_code, o_one_bit_samples})
        `CHK("gen mode", mem[16'h4003][15], o_delay_gen_mode)
        if (xon) `CHK("xbar", xexp, o_xbar_out)
        if (hon) `CHK("header", hexp, o_hdr_word)
        xon = 1;
        rexp = r ? rv(a) : 16'h0000;
        for (k = 0; k < 32; k++) xexp[k] = xi[mem[16'h2000 + k][4:0]];
        hexp = m((fc[0] ? 16'h3100 : 16'h3000) + hi);
        if (r && a == `PDR_A_IRQ_STATUS) st = 0;
        st = st | e[5:0];
        fc = fc + e[2];
        if (e[7]) dcnt++;
        if (e[7] && dcnt == m(16'h1004)) begin
            dcnt = 0;
            tk++;
            tcode = lastw;
        end
        // A wrap captures the word staged before this cycle's header word.
        if (e[6]) lastw = dw;
        if (w && wm.exists(a)) mem[a] = (m(a) & ~wm[a]) | (d & wm[a]);
    endtask

    task automatic end_of_test;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Free-running 200 MHz clock and a watchdog well beyond the run length.
    initial begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end

    // ==========
    // Main sequence.
    initial begin
        int i, j, k, a;
        reg_def(16'h000a, 0, 'h3f);
        reg_def(16'h1000, 'h55, 'hffff);
        reg_def(16'h1001, 'haa, 'hffff);
        reg_def(16'h1002, 'h33, 'hffff);
        reg_def(16'h1003, 'hcc, 'hffff);
        reg_def(16'h1004, 'h100, 0);
        reg_def(16'h2020, 0, 'h8007);
        reg_def(16'h4000, 0, 'hffff);
        reg_def(16'h4001, 'hfff0, 'hffff);
        reg_def(16'h4002, 'hffff, 'hffff);
        reg_def(16'h4003, 3, 'h8003);
        for (i = 0; i < 32; i++) reg_def(16'h2000 + i, i, 'h1f);
        for (i = 0; i < 480; i++) wm[16'h3000 + i % 240 + (i / 240) * 'h100] = 'hffff;
        foreach (mem[k]) al.push_back(k);
        al.push_back(16'h000b);
        al.push_back(16'h000c);
        al.push_back(16'h1007);
        al.push_back(16'h5000);
        al.push_back(16'h30f0);
        repeat (8) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        foreach (al[j]) cyc(0, 1, al[j], 0, 0);
        // Software preloads both banks before any output runs.
        for (i = 0; i < 480; i++) cyc(1, 0, 16'h3000 + i % 240 + (i / 240) * 'h100,
            $random(seed), 0);
        cyc(0, 1, 16'h3000, 0, 0);
        cyc(0, 1, 16'h31ef, 0, 0);
        hon = 1;
        for (j = 0; j < 2; j++) begin
            cyc(1, 0, 16'h000a, j * 'h3f, 0);
            for (i = 0; i < 6; i++) begin
                cyc(0, 0, 0, 0, 8'h01 << i);
                cyc(0, 1, 16'h000b, 0, 0);
                cyc(0, 1, 16'h000b, 0, 0);
            end
        end
        cyc(0, 1, 16'h000b, 0, 8'h3f);
        cyc(0, 1, 16'h000b, 0, 0);
        // After a frame start, software rewrites the delay words for the next frame.
        cyc(0, 0, 0, 0, 8'h04);
        for (i = 0; i < 4; i++) cyc(1, 0, 16'h4000 + i, $random(seed), 0);
        for (i = 0; i < 520; i++) cyc(0, 0, 0, 0, i[0] ? 8'h80 : 8'h40);
        al.push_back(16'h1005);
        al.push_back(16'h1006);
        foreach (al[j]) cyc(0, 1, al[j], 0, 0);
        for (i = 0; i < 3000; i++) begin
            a = al[$unsigned($random(seed)) % al.size()];
            k = $unsigned($random(seed)) % 3;
            cyc(k == 0, k == 1, a, $random(seed), $random(seed) & $random(seed) & $random(seed));
        end
        cyc(0, 0, 0, 0, 0);
        cyc(0, 0, 0, 0, 0);
        end_of_test();
    end
endmodule // testbench
